// >>> common/codec_chan_pkg.sv
// Constants and types shared by the channel local register files
package codec_chan_pkg;
    localparam int          CMD_DIR_BIT     = 7;
    localparam int          ADDR_W          = 7;
    localparam int          BYTE_W          = 8;
    localparam int          SAMPLE_W        = 16;
    localparam logic [6:0]  ADDR_LINE_PIN   = 7'h03;
    localparam logic [6:0]  ADDR_TX_SLOT    = 7'h04;
    localparam logic [6:0]  ADDR_RX_SLOT    = 7'h05;
    localparam logic [6:0]  ADDR_SAMPLE_LO  = 7'h06;
    localparam logic [6:0]  ADDR_SAMPLE_HI  = 7'h07;
    localparam logic [6:0]  ADDR_CHAN_OP    = 7'h08;
    localparam logic [6:0]  ADDR_TONE_EN    = 7'h09;
    localparam int          PIN_HOOK        = 0;
    localparam int          PIN_GKEY        = 1;
    localparam int          PIN_BIDIR_LSB   = 2;
    localparam int          PIN_BIDIR_MSB   = 4;
    localparam int          PIN_OUT_A       = 5;
    localparam int          PIN_OUT_B       = 6;
    localparam int          SLOT_MSB        = 6;
    localparam int          HWY_SEL_BIT     = 7;
    localparam int          OP_SLEEP        = 7;
    localparam int          OP_CUT          = 6;
    localparam int          OP_ADC_GAIN     = 5;
    localparam int          OP_DAC_GAIN     = 4;
    localparam int          TONE_A          = 0;
    localparam int          TONE_B          = 1;
    localparam int          TONE_FIX_LSB    = 2;
    localparam int          TONE_FIX_MSB    = 3;
    localparam logic [7:0]  RST_TX_SLOT     = 8'h00;
    localparam logic [7:0]  RST_RX_SLOT     = 8'h00;
    localparam logic [3:0]  RST_CHAN_OP     = 4'h8;
    localparam logic [3:0]  RST_TONE_EN     = 4'h0;
    localparam logic [1:0]  RST_LINE_OUT    = 2'h0;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [15:0] SAMPLE_ZERO     = 16'h0000;

    typedef enum logic [0:0] {
        CODING_COMPRESSED = 1'b0,
        CODING_LINEAR     = 1'b1
    } coding_type;
endpackage

// >>> common/reg_write_if.sv
// Register write strobe carried from the command decoder to pin logic
`timescale 1ns/1ps
interface reg_write_if;
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] wdata;

    modport source (output wr_en, output addr, output wdata);
    modport target (input wr_en, input addr, input wdata);
endinterface

// >>> design/line_pin_port.sv
// Line interface pins: output latches, bidirectional pin drive, pin snapshot
`timescale 1ns/1ps
module line_pin_port (
    input  wire logic   clk,
    input  wire logic   reset_n,
    input  wire logic   clk_en,
    reg_write_if.target bus,
    input  wire logic   hook_in,
    input  wire logic   gkey_in,
    input  wire logic [2:0] bidir_in,
    input  wire logic [2:0] bidir_is_out,
    input  wire logic [2:0] global_out,
    output logic [2:0]  bidir_out,
    output logic [2:0]  bidir_oe,
    output logic [1:0]  line_out,
    output logic [7:0]  pin_byte
);
    logic [1:0] line_out_r;
    logic [2:0] bidir_out_r;
    logic [2:0] bidir_oe_r;
    logic [7:0] pin_byte_r;
    logic [2:0] bidir_level;

    // Only the two pure outputs are stored; bidir bits written here are dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_out_r <= codec_chan_pkg::RST_LINE_OUT;
        end else if (clk_en && bus.wr_en && bus.addr == codec_chan_pkg::ADDR_LINE_PIN) begin
            line_out_r <= bus.wdata[codec_chan_pkg::PIN_OUT_B:codec_chan_pkg::PIN_OUT_A]; // [RULE_02]
        end
    end

    // Output pins follow the global pin registers only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bidir_out_r <= 3'h0;
            bidir_oe_r  <= 3'h0;
        end else if (clk_en) begin
            bidir_out_r <= global_out; // [RULE_03]
            bidir_oe_r  <= bidir_is_out;
        end
    end

    // A pin driven by us reads back its driven value, otherwise its level
    assign bidir_level = (bidir_oe_r & bidir_out_r) | (~bidir_oe_r & bidir_in);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_byte_r <= codec_chan_pkg::BYTE_ZERO;
        end else if (clk_en) begin
            pin_byte_r <= {1'b0, line_out_r, bidir_level, gkey_in, hook_in}; // [RULE_02]
        end
    end

    assign bidir_out = bidir_out_r;
    assign bidir_oe  = bidir_oe_r;
    assign line_out  = line_out_r;
    assign pin_byte  = pin_byte_r;
endmodule // line_pin_port

// >>> design/tx_sample_monitor.sv
// Transmit sample capture: feeds the highway and a side copy for reads
`timescale 1ns/1ps
module tx_sample_monitor (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       clk_en,
    input  wire logic [15:0]                sample_in,
    input  wire logic                       sample_valid,
    input  wire codec_chan_pkg::coding_type coding,
    output logic [7:0]                      lo_byte,
    output logic [7:0]                      hi_byte,
    output logic [15:0]                     hwy_sample,
    output logic                            hwy_valid
);
    logic [15:0] hwy_sample_r;
    logic        hwy_valid_r;
    logic [7:0]  lo_byte_r;
    logic [7:0]  hi_byte_r;

    // The highway path has no read input at all, so a read can never alter it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hwy_sample_r <= codec_chan_pkg::SAMPLE_ZERO;
            hwy_valid_r  <= 1'b0;
        end else if (clk_en) begin
            hwy_valid_r <= sample_valid; // [RULE_09]
            if (sample_valid) begin
                hwy_sample_r <= sample_in; // [RULE_09]
            end
        end
    end

    // Monitor copy, compressed samples sit in the low byte
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lo_byte_r <= codec_chan_pkg::BYTE_ZERO;
            hi_byte_r <= codec_chan_pkg::BYTE_ZERO;
        end else if (clk_en && sample_valid) begin
            lo_byte_r <= sample_in[7:0]; // [RULE_08]
            if (coding == codec_chan_pkg::CODING_LINEAR) begin
                hi_byte_r <= sample_in[15:8];
            end else begin
                hi_byte_r <= codec_chan_pkg::BYTE_ZERO; // [RULE_10]
            end
        end
    end

    assign lo_byte    = lo_byte_r;
    assign hi_byte    = hi_byte_r;
    assign hwy_sample = hwy_sample_r;
    assign hwy_valid  = hwy_valid_r;
endmodule // tx_sample_monitor

// >>> design/codec_channel_local_regs.sv
// Per-channel local register set of the codec, reached by command bytes
// Summary of operation
// [RULE_01] Command bit 7 set means write, clear means read; low seven bits address.
// [RULE_02] Pin data: hook bit0, ground key bit1, bidir bits 2-4, outputs 5-6.
// [RULE_03] Bidir pins set as outputs ignore pin-data writes; global values drive them.
// [RULE_04] Seven-bit transmit slot field picks slot 0 to 127, default zero.
// [RULE_05] Transmit highway select: clear first highway (default), set second.
// [RULE_06] Seven-bit receive slot field picks slot 0 to 127, default zero.
// [RULE_07] Receive highway select: clear first highway (default), set second.
// [RULE_08] Sample-low reads low byte of linear sample or whole compressed sample.
// [RULE_09] Reading sample monitors leaves the sample sent on the highway unchanged.
// [RULE_10] Sample-high reads upper linear byte, all zeros in compressed coding.
// [RULE_11] Power-down bit set powers channel down, reset default; clear runs normally.
// [RULE_12] Receive-cut bit set cuts the PCM receive path; clear (default) normal.
// [RULE_13] A/D gain bit: clear 0 dB default, set +6 dB.
// [RULE_14] D/A gain bit: clear 0 dB default, set -6 dB.
// [RULE_15] Host writes zeros to the low four bits of channel operation.
// [RULE_16] Tone enable bits 1 and 0 turn generators on; both off by default.
// [RULE_17] Host writes ones to bits 3 and 2 of tone enable.
// [RULE_18] Channel logic works at any permitted master clock from 1.536 to 8.192 MHz.
// [RULE_19] Writes to read-only sample monitor registers are ignored entirely.
`timescale 1ns/1ps
module codec_channel_local_regs (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic        CMD_VALID,
    input  wire logic [7:0]  CMD_BYTE,
    input  wire logic [7:0]  CMD_DATA,
    output logic [7:0]       RD_DATA,
    output logic             RD_VALID,
    input  wire logic        HOOK_SENSE_IN,
    input  wire logic        GROUND_KEY_IN,
    input  wire logic [2:0]  BIDIR_LINE_PIN_I,
    output logic [2:0]       BIDIR_LINE_PIN_O,
    output logic [2:0]       BIDIR_LINE_PIN_OE,
    input  wire logic [2:0]  BIDIR_PIN_IS_OUT,
    input  wire logic        GLOBAL_PIN_OUT_A,
    input  wire logic        GLOBAL_PIN_OUT_B,
    input  wire logic        GLOBAL_PIN_OUT_C,
    output logic             LINE_OUT_A,
    output logic             LINE_OUT_B,
    input  wire logic        LINEAR_CODING,
    input  wire logic [15:0] TX_SAMPLE_IN,
    input  wire logic        TX_SAMPLE_VALID,
    output logic [15:0]      TX_HWY_SAMPLE,
    output logic             TX_HWY_VALID,
    output logic [6:0]       TX_SLOT_FIELD,
    output logic             TX_HIGHWAY_SEL,
    output logic [6:0]       RX_SLOT_FIELD,
    output logic             RX_HIGHWAY_SEL,
    output logic             CHAN_SLEEP,
    output logic             RX_PATH_CUT,
    output logic             ADC_GAIN_STEP,
    output logic             DAC_GAIN_STEP,
    output logic             TONE_GEN_A_ON,
    output logic             TONE_GEN_B_ON
);
    reg_write_if wr_bus ();

    logic       is_write;
    logic       is_read;
    logic [6:0] cmd_addr;
    logic [7:0] tx_slot_r;
    logic [7:0] rx_slot_r;
    logic [3:0] chan_op_r;
    logic [3:0] tone_en_r;
    logic [7:0] rd_data_r;
    logic       rd_valid_r;
    logic [7:0] rd_data_nxt;
    logic [7:0] pin_byte;
    logic [7:0] sample_lo;
    logic [7:0] sample_hi;
    logic [1:0] line_out;
    codec_chan_pkg::coding_type coding;

    // Returns true when a write command targets the given register
    function automatic logic write_hits(input logic wr, input logic [6:0] a,
                                        input logic [6:0] target);
        write_hits = wr && (a == target);
    endfunction

    // Direction and address split out of the command byte
    assign is_write = CMD_VALID && CMD_BYTE[codec_chan_pkg::CMD_DIR_BIT]; // [RULE_01]
    assign is_read  = CMD_VALID && !CMD_BYTE[codec_chan_pkg::CMD_DIR_BIT]; // [RULE_01]
    assign cmd_addr = CMD_BYTE[codec_chan_pkg::ADDR_W-1:0]; // [RULE_01]

    assign wr_bus.wr_en = is_write;
    assign wr_bus.addr  = cmd_addr;
    assign wr_bus.wdata = CMD_DATA;

    assign coding = LINEAR_CODING ? codec_chan_pkg::CODING_LINEAR
                                  : codec_chan_pkg::CODING_COMPRESSED;

    // All state is synchronous to the one master clock and counts no time,
    // so any permitted master clock rate works unchanged
    line_pin_port u_pins (
        .clk          (CLK), // [RULE_18]
        .reset_n      (RESET_N),
        .clk_en       (CLK_EN),
        .bus          (wr_bus),
        .hook_in      (HOOK_SENSE_IN),
        .gkey_in      (GROUND_KEY_IN),
        .bidir_in     (BIDIR_LINE_PIN_I),
        .bidir_is_out (BIDIR_PIN_IS_OUT),
        .global_out   ({GLOBAL_PIN_OUT_C, GLOBAL_PIN_OUT_B, GLOBAL_PIN_OUT_A}),
        .bidir_out    (BIDIR_LINE_PIN_O),
        .bidir_oe     (BIDIR_LINE_PIN_OE),
        .line_out     (line_out),
        .pin_byte     (pin_byte)
    );

    tx_sample_monitor u_sample (
        .clk          (CLK),
        .reset_n      (RESET_N),
        .clk_en       (CLK_EN),
        .sample_in    (TX_SAMPLE_IN),
        .sample_valid (TX_SAMPLE_VALID),
        .coding       (coding),
        .lo_byte      (sample_lo),
        .hi_byte      (sample_hi),
        .hwy_sample   (TX_HWY_SAMPLE),
        .hwy_valid    (TX_HWY_VALID)
    );

    // Transmit slot and highway
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_slot_r <= codec_chan_pkg::RST_TX_SLOT; // [RULE_04]
        end else if (CLK_EN && write_hits(is_write, cmd_addr, codec_chan_pkg::ADDR_TX_SLOT)) begin
            tx_slot_r <= CMD_DATA; // [RULE_05]
        end
    end

    // Receive slot and highway
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_slot_r <= codec_chan_pkg::RST_RX_SLOT; // [RULE_06]
        end else if (CLK_EN && write_hits(is_write, cmd_addr, codec_chan_pkg::ADDR_RX_SLOT)) begin
            rx_slot_r <= CMD_DATA; // [RULE_07]
        end
    end

    // Channel operation keeps only the upper nibble; the lower one must be zero
    // on writes, so it is not stored and always reads zero
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chan_op_r <= codec_chan_pkg::RST_CHAN_OP; // [RULE_11]
        end else if (CLK_EN && write_hits(is_write, cmd_addr, codec_chan_pkg::ADDR_CHAN_OP)) begin
            chan_op_r <= CMD_DATA[7:4]; // [RULE_12]
        end
    end

    // Tone enables; the fixed bits 3:2 are stored so the host can read them back
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tone_en_r <= codec_chan_pkg::RST_TONE_EN; // [RULE_16]
        end else if (CLK_EN && write_hits(is_write, cmd_addr, codec_chan_pkg::ADDR_TONE_EN)) begin
            tone_en_r <= CMD_DATA[codec_chan_pkg::TONE_FIX_MSB:0]; // [RULE_16]
        end
    end

    // Read mux; sample addresses have no write path at all
    always_comb begin
        rd_data_nxt = codec_chan_pkg::BYTE_ZERO;
        case (cmd_addr)
            codec_chan_pkg::ADDR_LINE_PIN:  rd_data_nxt = pin_byte; // [RULE_02]
            codec_chan_pkg::ADDR_TX_SLOT:   rd_data_nxt = tx_slot_r;
            codec_chan_pkg::ADDR_RX_SLOT:   rd_data_nxt = rx_slot_r;
            codec_chan_pkg::ADDR_SAMPLE_LO: rd_data_nxt = sample_lo; // [RULE_08]
            codec_chan_pkg::ADDR_SAMPLE_HI: rd_data_nxt = sample_hi; // [RULE_10]
            codec_chan_pkg::ADDR_CHAN_OP:   rd_data_nxt = {chan_op_r, 4'h0};
            codec_chan_pkg::ADDR_TONE_EN:   rd_data_nxt = {4'h0, tone_en_r};
            default:                        rd_data_nxt = codec_chan_pkg::BYTE_ZERO;
        endcase
    end

    // Read answer one cycle after the command; a write never answers [RULE_19]
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_data_r  <= codec_chan_pkg::BYTE_ZERO;
            rd_valid_r <= 1'b0;
        end else if (CLK_EN) begin
            rd_valid_r <= is_read; // [RULE_01]
            if (is_read) begin
                rd_data_r <= rd_data_nxt; // [RULE_09]
            end
        end
    end

    assign RD_DATA        = rd_data_r;
    assign RD_VALID       = rd_valid_r;
    assign LINE_OUT_A     = line_out[0];
    assign LINE_OUT_B     = line_out[1];
    assign TX_SLOT_FIELD  = tx_slot_r[codec_chan_pkg::SLOT_MSB:0]; // [RULE_04]
    assign TX_HIGHWAY_SEL = tx_slot_r[codec_chan_pkg::HWY_SEL_BIT]; // [RULE_05]
    assign RX_SLOT_FIELD  = rx_slot_r[codec_chan_pkg::SLOT_MSB:0]; // [RULE_06]
    assign RX_HIGHWAY_SEL = rx_slot_r[codec_chan_pkg::HWY_SEL_BIT]; // [RULE_07]
    assign CHAN_SLEEP     = chan_op_r[codec_chan_pkg::OP_SLEEP - 4]; // [RULE_11]
    assign RX_PATH_CUT    = chan_op_r[codec_chan_pkg::OP_CUT - 4]; // [RULE_12]
    assign ADC_GAIN_STEP  = chan_op_r[codec_chan_pkg::OP_ADC_GAIN - 4]; // [RULE_13]
    assign DAC_GAIN_STEP  = chan_op_r[codec_chan_pkg::OP_DAC_GAIN - 4]; // [RULE_14]
    assign TONE_GEN_A_ON  = tone_en_r[codec_chan_pkg::TONE_A]; // [RULE_16]
    assign TONE_GEN_B_ON  = tone_en_r[codec_chan_pkg::TONE_B]; // [RULE_16]
endmodule // codec_channel_local_regs

// >>> dv/codec_channel_local_regs_props.sv
// Concurrent checks on the ports of the channel local register block
`timescale 1ns/1ps
module codec_channel_local_regs_props (
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        CLK_EN,
    input wire logic        CMD_VALID,
    input wire logic [7:0]  CMD_BYTE,
    input wire logic [7:0]  CMD_DATA,
    input wire logic        RD_VALID,
    input wire logic [2:0]  BIDIR_LINE_PIN_OE,
    input wire logic [2:0]  BIDIR_PIN_IS_OUT,
    input wire logic [15:0] TX_SAMPLE_IN,
    input wire logic        TX_SAMPLE_VALID,
    input wire logic [15:0] TX_HWY_SAMPLE,
    input wire logic        TX_HWY_VALID,
    input wire logic [6:0]  TX_SLOT_FIELD,
    input wire logic        TX_HIGHWAY_SEL,
    input wire logic        CHAN_SLEEP,
    input wire logic        RX_PATH_CUT,
    input wire logic        ADC_GAIN_STEP,
    input wire logic        DAC_GAIN_STEP,
    input wire logic        TONE_GEN_A_ON,
    input wire logic        TONE_GEN_B_ON
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic rd_go;
    logic wr_go;
    assign rd_go = CMD_VALID && CLK_EN && !CMD_BYTE[7];
    assign wr_go = CMD_VALID && CLK_EN && CMD_BYTE[7];
    a_read_gets_answer: assert property (rd_go |=> RD_VALID)
        else $error("read command got no answer");
    a_no_stray_answer: assert property (CLK_EN && !rd_go |=> !RD_VALID)
        else $error("read answer without read command");
    a_tx_slot_write: assert property (wr_go && CMD_BYTE[6:0] == 7'h04
        |=> {TX_HIGHWAY_SEL, TX_SLOT_FIELD} == $past(CMD_DATA)) else $error("tx slot write");
    // Writes elsewhere, read-only monitors included, must not touch the slot
    a_tx_slot_hold: assert property (!(wr_go && CMD_BYTE[6:0] == 7'h04)
        |=> $stable({TX_HIGHWAY_SEL, TX_SLOT_FIELD})) else $error("tx slot changed");
    a_chan_op_write: assert property (wr_go && CMD_BYTE[6:0] == 7'h08
        |=> {CHAN_SLEEP, RX_PATH_CUT, ADC_GAIN_STEP, DAC_GAIN_STEP} == $past(CMD_DATA[7:4]))
        else $error("channel operation write");
    a_tone_write: assert property (wr_go && CMD_BYTE[6:0] == 7'h09
        |=> {TONE_GEN_B_ON, TONE_GEN_A_ON} == $past(CMD_DATA[1:0])) else $error("tone write");
    a_sample_passes: assert property (CLK_EN && TX_SAMPLE_VALID
        |=> TX_HWY_VALID && TX_HWY_SAMPLE == $past(TX_SAMPLE_IN)) else $error("sample lost");
    a_sample_holds: assert property (CLK_EN && !TX_SAMPLE_VALID
        |=> !TX_HWY_VALID && $stable(TX_HWY_SAMPLE)) else $error("sample disturbed");
    // The edge that releases reset still clears the enables, so it is left out
    a_bidir_oe_follow: assert property (CLK_EN && RESET_N
        |=> BIDIR_LINE_PIN_OE == $past(BIDIR_PIN_IS_OUT)) else $error("bidir enable");
endmodule // codec_channel_local_regs_props

// >>> dv/host_cmd_model.sv
// Host model issuing command and data bytes to the channel registers
`timescale 1ns/1ps
module host_cmd_model (
    input  wire logic       clk,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic [7:0]      cmd_data,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
        cmd_data  = 8'h00;
    end
    // Idle lanes show inverted bytes so a late sample is caught
    task automatic issue(input logic [7:0] cb, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_byte  <= cb;
        cmd_data  <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~cb;
        cmd_data  <= ~d;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 7'h08) v[3:0] = 4'h0;
        if (a == 7'h09) v[3:2] = 2'h3;
        issue({1'b1, a}, v);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
        issue({1'b0, a}, 8'h00);
        ok = 1'b0;
        d  = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rd_valid === 1'b1) begin
                d  = rd_data;
                ok = 1'b1;
            end else @(posedge clk);
        end
    endtask
endmodule // host_cmd_model

// >>> dv/codec_channel_local_regs_tb_top.sv
// Self-checking bench for the channel local register set
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module codec_channel_local_regs_tb_top;
    logic        clk, reset_n, clk_en, cmd_valid, rd_valid, hook, gkey, g_a, g_b, g_c;
    logic        out_a, out_b, lin, smp_v, hwy_v, tx_hs, rx_hs, slp, cut, adc, dac, ta, tb;
    logic [7:0]  cmd_byte, cmd_data, rd_data;
    logic [2:0]  pin_ext, pin_i, pin_o, pin_oe, is_out;
    logic [15:0] smp, hwy;
    logic [6:0]  tx_slot, rx_slot;
    logic [7:0]  sv [4] = '{8'h85, 8'h7f, 8'h80, 8'hff};
    logic [7:0]  ops [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'hf0, 8'h00};
    logic [7:0]  tones [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
    int          err_total, checks_done;
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & pin_ext);
    codec_channel_local_regs dut (.CLK(clk), .RESET_N(reset_n), .CLK_EN(clk_en),
        .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte), .CMD_DATA(cmd_data), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .HOOK_SENSE_IN(hook), .GROUND_KEY_IN(gkey),
        .BIDIR_LINE_PIN_I(pin_i), .BIDIR_LINE_PIN_O(pin_o), .BIDIR_LINE_PIN_OE(pin_oe),
        .BIDIR_PIN_IS_OUT(is_out), .GLOBAL_PIN_OUT_A(g_a), .GLOBAL_PIN_OUT_B(g_b),
        .GLOBAL_PIN_OUT_C(g_c), .LINE_OUT_A(out_a), .LINE_OUT_B(out_b), .LINEAR_CODING(lin),
        .TX_SAMPLE_IN(smp), .TX_SAMPLE_VALID(smp_v), .TX_HWY_SAMPLE(hwy), .TX_HWY_VALID(hwy_v),
        .TX_SLOT_FIELD(tx_slot), .TX_HIGHWAY_SEL(tx_hs), .RX_SLOT_FIELD(rx_slot),
        .RX_HIGHWAY_SEL(rx_hs), .CHAN_SLEEP(slp), .RX_PATH_CUT(cut), .ADC_GAIN_STEP(adc),
        .DAC_GAIN_STEP(dac), .TONE_GEN_A_ON(ta), .TONE_GEN_B_ON(tb));
    host_cmd_model h (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .cmd_data(cmd_data), .rd_data(rd_data), .rd_valid(rd_valid));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit         ok;
        h.rd(a, d, ok);
        if (!ok) begin
            err_total++;
            $display("MISMATCH %0t no read answer", $time);
            final_report();
        end else begin
            `CHK(d, e)
        end
    endtask
    // Lin is switched with the sample since coding counts at capture
    task automatic send(input logic [15:0] s, input logic l);
        @(posedge clk);
        smp_v <= 1'b1;
        smp   <= s;
        lin   <= l;
        @(posedge clk);
        smp_v <= 1'b0;
        smp   <= ~s;
        #1;
        `CHK({hwy_v, hwy}, {1'b1, s})
    endtask
    initial begin
        {reset_n, hook, gkey, is_out, g_b, smp_v, smp} = '0;
        {clk_en, g_a, g_c, lin} = 4'hf;
        pin_ext = 3'h2;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        `CHK({slp, cut, adc, dac}, 4'h8)
        `CHK({ta, tb}, 2'h0)
        `CHK({tx_hs, tx_slot, rx_hs, rx_slot}, 16'h0)
        rdc(7'h08, 8'h80);
        $display("test reset_values done");
        foreach (sv[i]) begin
            h.wr(7'h04, sv[i]);
            h.wr(7'h05, ~sv[i]);
            #1;
            `CHK({tx_hs, tx_slot}, sv[i])
            `CHK({rx_hs, rx_slot}, ~sv[i])
            rdc(7'h04, sv[i]);
            rdc(7'h05, ~sv[i]);
        end
        $display("test slots done");
        foreach (ops[i]) begin
            h.wr(7'h08, ops[i] | 8'h0f);
            #1;
            `CHK({slp, cut, adc, dac}, ops[i][7:4])
            rdc(7'h08, ops[i]);
        end
        foreach (tones[i]) begin
            h.wr(7'h09, tones[i]);
            #1;
            `CHK({tb, ta}, tones[i][1:0])
            rdc(7'h09, tones[i] | 8'h0c);
        end
        $display("test operation_tone done");
        send(16'h1234, 1'b1);
        rdc(7'h06, 8'h34);
        rdc(7'h07, 8'h12);
        h.wr(7'h06, 8'haa);
        h.wr(7'h07, 8'h55);
        rdc(7'h06, 8'h34);
        rdc(7'h07, 8'h12);
        rdc(7'h04, 8'hff);
        `CHK({hwy_v, hwy}, 17'h01234)
        send(16'habcd, 1'b0);
        rdc(7'h06, 8'hcd);
        rdc(7'h07, 8'h00);
        $display("test sample_monitor done");
        @(posedge clk);
        hook <= 1'b1;
        h.wr(7'h03, 8'h60);
        #1;
        `CHK({out_b, out_a}, 2'h3)
        rdc(7'h03, 8'h69);
        @(posedge clk);
        is_out <= 3'h7;
        h.wr(7'h03, 8'h08);
        #1;
        `CHK({pin_oe, pin_o}, 6'h3d)
        rdc(7'h03, 8'h15);
        $display("test line_pins done");
        rdc(7'h7f, 8'h00);
        h.wr(7'h7f, 8'h5a);
        @(posedge clk);
        clk_en <= 1'b0;
        h.wr(7'h04, 8'h11);
        clk_en <= 1'b1;
        rdc(7'h04, 8'hff);
        $display("test unmapped_frozen done");
        // Reset in mid-run must bring every written register back to its default
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        `CHK({slp, cut, adc, dac, ta, tb, tx_hs, tx_slot}, 14'h2000)
        `CHK({out_b, out_a, pin_oe, pin_o}, 8'h00)
        rdc(7'h09, 8'h00);
        rdc(7'h05, 8'h00);
        $display("test mid_reset done");
        final_report();
    end
endmodule // codec_channel_local_regs_tb_top
bind codec_channel_local_regs codec_channel_local_regs_props u_props (.CLK, .RESET_N,
    .CLK_EN, .CMD_VALID, .CMD_BYTE, .CMD_DATA, .RD_VALID, .BIDIR_LINE_PIN_OE,
    .BIDIR_PIN_IS_OUT, .TX_SAMPLE_IN, .TX_SAMPLE_VALID, .TX_HWY_SAMPLE, .TX_HWY_VALID,
    .TX_SLOT_FIELD, .TX_HIGHWAY_SEL, .CHAN_SLEEP, .RX_PATH_CUT, .ADC_GAIN_STEP,
    .DAC_GAIN_STEP, .TONE_GEN_A_ON, .TONE_GEN_B_ON);
